/* logic/vfg_defines.svh */
/*
 Register offsets, field positions, reset values and timing counts of the
 driver supply monitor and peer fault group block.
 Assumes it is included once per compilation unit by its bare name.
*/
`ifndef VFG_DEFINES_SVH
`define VFG_DEFINES_SVH

`define VFG_OFS_LISTEN      8'hf0
`define VFG_OFS_CAPTURE     8'hf3
`define VFG_OFS_OVER_LIMIT  8'hf5
`define VFG_OFS_UNDER_LIMIT 8'hf6
`define VFG_OFS_OVER_ACTION 8'hf8

`define VFG_RST_LISTEN      32'h0000_0000
`define VFG_RST_BYTE        8'h00
`define VFG_RST_OVER_LIMIT  16'h0000
`define VFG_RST_UNDER_LIMIT 16'h0000

`define VFG_CAP_COPY        8'h01
`define VFG_CAP_STORE       8'h02
`define VFG_CAP_ERASE       8'h03

`define VFG_ACT_RESP_HI     7
`define VFG_ACT_RESP_LO     6
`define VFG_ACT_TRY_HI      5
`define VFG_ACT_TRY_LO      3
`define VFG_ACT_DLY_HI      2
`define VFG_ACT_DLY_LO      0
`define VFG_RESP_IGNORE     2'b00
`define VFG_RESP_RESUME     2'b11
`define VFG_TRY_NEVER       3'b000
`define VFG_TRY_FOREVER     3'b111

`define VFG_MANT_HI         10
`define VFG_WARN_OV_NUM     9
`define VFG_WARN_UV_NUM     11
`define VFG_WARN_DEN        10
`define VFG_RESUME_NUM      19
`define VFG_RESUME_DEN      20

`define VFG_CLK_KHZ         40000
`define VFG_TICK_MS         1
`define VFG_MS_CYCLES       (`VFG_TICK_MS * `VFG_CLK_KHZ)
`define VFG_RETRY_STEP_MS   35

`endif

/* logic/vfg_pkg.sv */
/*
 Types shared by the fault group block and its surroundings.
 Assumes the defines header is compiled alongside.
*/
package vfg_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [31:0] data;
    } vfg_cmd_s;

    typedef struct packed {
        logic       valid;
        logic       fault;
        logic [4:0] rail_id;
    } vfg_peer_evt_s;

    typedef struct packed {
        logic copy;
        logic store;
        logic erase;
    } vfg_nvm_op_s;

    typedef enum logic [3:0] {
        VFG_ST_RUN   = 4'b0001,
        VFG_ST_DELAY = 4'b0010,
        VFG_ST_HOLD  = 4'b0100,
        VFG_ST_LATCH = 4'b1000
    } vfg_ov_state_e;

endpackage : vfg_pkg

/* logic/vfg_fault_group.sv */
/*
 Driver supply monitor limits, over-voltage response, snapshot memory
 operations and peer fault group listening behind decoded PMBus commands.
 Assumes a PMBus front end on core_clk_in delivers decoded command strobes,
 the supply reading arrives on core_clk_in in the limits' exponent, and peer
 fault events arrive on the group bus clock.
*/
`timescale 1ns/10ps
`include "vfg_defines.svh"

module vfg_fault_group #(
    parameter int unsigned MS_CYCLES = `VFG_MS_CYCLES
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  link_clk_in,
    input  vfg_pkg::vfg_cmd_s          cmd_in,
    output logic [31:0]                rd_data_out,
    output logic                       rd_valid_out,
    input  vfg_pkg::vfg_peer_evt_s     peer_evt_in,
    input  wire logic                  spread_mode_in,
    input  wire logic                  seq_enable_in,
    input  wire logic                  share_peers_off_in,
    input  wire logic                  run_enable_in,
    input  wire logic [15:0]           supply_volts_in,
    input  wire logic                  clear_faults_in,
    input  wire logic                  unmasked_fault_in,
    output logic                       out_enable_out,
    output logic                       seq_shutdown_out,
    output logic                       rail_shutdown_out,
    output logic                       alert_n_out,
    output logic                       over_fault_out,
    output logic                       under_fault_out,
    output logic                       over_warn_out,
    output logic                       under_warn_out,
    output logic                       snap_refresh_out,
    output vfg_pkg::vfg_nvm_op_s       nvm_op_out
);

    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    // Scales the mantissa, keeps the exponent; saturates to largest positive
    function automatic logic [15:0] scale_lin(input logic [15:0] v, input logic [4:0] num);
        logic signed [17:0] p;
        p = 18'(($signed({{7{v[10]}}, v[10:0]}) * $signed({1'b0, num})) / `VFG_WARN_DEN);
        if (p > 18'sd1023) begin
            scale_lin = {v[15:11], 11'h3ff};
        end else begin
            scale_lin = {v[15:11], p[10:0]};
        end
    endfunction : scale_lin

    function automatic logic signed [11:0] mant(input logic [15:0] v);
        mant = $signed({v[10], v[10:0]});
    endfunction : mant

    logic [31:0] listen_mask_q;
    logic [7:0]  capture_op_q;
    logic [15:0] over_limit_q;
    logic [15:0] under_limit_q;
    logic [15:0] over_warn_q;
    logic [15:0] under_warn_q;
    logic [7:0]  over_action_q;

    // Link side: latest fault state per peer rail
    logic [31:0] peer_fault_q;
    logic [31:0] peer_meta_q;
    logic [31:0] peer_sync_q;
    logic [1:0]  share_off_q;

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            peer_fault_q <= 32'h0000_0000;
        end else if (peer_evt_in.valid) begin
            peer_fault_q[peer_evt_in.rail_id] <= peer_evt_in.fault;
        end
    end

    // Each bit is an independent level, so a plain double flop suffices
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            peer_meta_q <= 32'h0000_0000;
            peer_sync_q <= 32'h0000_0000;
            share_off_q <= 2'b00;
        end else begin
            peer_meta_q <= peer_fault_q;
            peer_sync_q <= peer_meta_q;
            share_off_q <= {share_off_q[0], share_peers_off_in};
        end
    end

    // Register writes
    logic wr_listen;
    logic wr_capture;
    logic wr_over;
    logic wr_under;
    logic wr_action;

    assign wr_listen  = cmd_in.wr && (cmd_in.code == `VFG_OFS_LISTEN);
    assign wr_capture = cmd_in.wr && (cmd_in.code == `VFG_OFS_CAPTURE);
    assign wr_over    = cmd_in.wr && (cmd_in.code == `VFG_OFS_OVER_LIMIT);
    assign wr_under   = cmd_in.wr && (cmd_in.code == `VFG_OFS_UNDER_LIMIT);
    assign wr_action  = cmd_in.wr && (cmd_in.code == `VFG_OFS_OVER_ACTION);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            listen_mask_q <= `VFG_RST_LISTEN;
            capture_op_q  <= `VFG_RST_BYTE;
            over_action_q <= `VFG_RST_BYTE;
        end else begin
            if (wr_listen) begin
                listen_mask_q <= cmd_in.data;
            end
            if (wr_capture) begin
                capture_op_q <= cmd_in.data[7:0];
            end
            if (wr_action) begin
                over_action_q <= cmd_in.data[7:0];
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            over_limit_q  <= `VFG_RST_OVER_LIMIT;
            under_limit_q <= `VFG_RST_UNDER_LIMIT;
            over_warn_q   <= `VFG_RST_OVER_LIMIT;
            under_warn_q  <= `VFG_RST_UNDER_LIMIT;
        end else begin
            if (wr_over) begin
                over_limit_q <= cmd_in.data[15:0];
                over_warn_q  <= scale_lin(cmd_in.data[15:0], 5'(`VFG_WARN_OV_NUM));
            end
            if (wr_under) begin
                under_limit_q <= cmd_in.data[15:0];
                under_warn_q  <= scale_lin(cmd_in.data[15:0], 5'(`VFG_WARN_UV_NUM));
            end
        end
    end

    // Reads; unmapped codes answer zero
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out  <= 32'h0000_0000;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= cmd_in.rd;
            if (cmd_in.rd) begin
                case (cmd_in.code)
                    `VFG_OFS_LISTEN:      rd_data_out <= listen_mask_q;
                    `VFG_OFS_CAPTURE:     rd_data_out <= {24'h00_0000, capture_op_q};
                    `VFG_OFS_OVER_LIMIT:  rd_data_out <= {16'h0000, over_limit_q};
                    `VFG_OFS_UNDER_LIMIT: rd_data_out <= {16'h0000, under_limit_q};
                    `VFG_OFS_OVER_ACTION: rd_data_out <= {24'h00_0000, over_action_q};
                    default:              rd_data_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Supply comparisons in the limits' own exponent
    logic over_raw;
    logic under_raw;
    logic below_resume;
    logic signed [17:0] sup_x20;
    logic signed [17:0] lim_x19;
    // Widen before scaling; a 12-bit product would wrap
    logic signed [17:0] sup_wide;
    logic signed [17:0] lim_wide;

    assign over_raw  = mant(supply_volts_in) > mant(over_limit_q);
    assign under_raw = mant(supply_volts_in) < mant(under_limit_q);
    assign sup_wide  = 18'(mant(supply_volts_in));
    assign lim_wide  = 18'(mant(over_limit_q));
    assign sup_x20   = sup_wide * 18'(`VFG_RESUME_DEN);
    assign lim_x19   = lim_wide * 18'(`VFG_RESUME_NUM);
    assign below_resume = sup_x20 < lim_x19;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            over_fault_out  <= 1'b0;
            under_fault_out <= 1'b0;
            over_warn_out   <= 1'b0;
            under_warn_out  <= 1'b0;
        end else begin
            // Set wins over a clear in the same cycle
            over_fault_out  <= over_raw | (over_fault_out & ~clear_faults_in);
            under_fault_out <= under_raw | (under_fault_out & ~clear_faults_in);
            over_warn_out   <= mant(supply_volts_in) > mant(over_warn_q);
            under_warn_out  <= mant(supply_volts_in) < mant(under_warn_q);
        end
    end

    assign alert_n_out = ~(over_fault_out | under_fault_out);

    // Over-voltage response
    vfg_pkg::vfg_ov_state_e st_q;
    logic [1:0]  resp;
    logic [2:0]  tries_cfg;
    logic [2:0]  tries_q;
    logic [8:0]  delay_ms;
    logic [8:0]  ms_cnt_q;
    logic [15:0] tick_cnt_q;
    logic        tick;
    logic        ov_trip;
    logic        ov_off;

    assign resp      = over_action_q[`VFG_ACT_RESP_HI:`VFG_ACT_RESP_LO];
    assign tries_cfg = over_action_q[`VFG_ACT_TRY_HI:`VFG_ACT_TRY_LO];
    assign delay_ms  = 9'((over_action_q[`VFG_ACT_DLY_HI:`VFG_ACT_DLY_LO] + 4'd1)
                          * `VFG_RETRY_STEP_MS);
    assign ov_trip   = over_raw && (resp != `VFG_RESP_IGNORE);
    assign tick      = (tick_cnt_q == MS_LAST);
    assign ov_off    = (st_q != vfg_pkg::VFG_ST_RUN);

    // Count may wrap while held; only the delay state reads it
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_cnt_q <= 16'h0000;
            ms_cnt_q   <= 9'h000;
        end else if (st_q == vfg_pkg::VFG_ST_RUN) begin
            tick_cnt_q <= 16'h0000;
            ms_cnt_q   <= 9'h000;
        end else begin
            tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
            if (tick) begin
                ms_cnt_q <= ms_cnt_q + 9'h001;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q    <= vfg_pkg::VFG_ST_RUN;
            tries_q <= 3'b000;
        end else begin
            case (st_q)
                vfg_pkg::VFG_ST_RUN: begin
                    if (!run_enable_in) begin
                        tries_q <= 3'b000;
                    end else if (ov_trip) begin
                        if (resp == `VFG_RESP_RESUME || tries_cfg == `VFG_TRY_NEVER) begin
                            st_q <= vfg_pkg::VFG_ST_HOLD;
                        end else if (tries_cfg != `VFG_TRY_FOREVER && tries_q >= tries_cfg) begin
                            st_q <= vfg_pkg::VFG_ST_LATCH;
                        end else begin
                            st_q <= vfg_pkg::VFG_ST_DELAY;
                        end
                    end
                end
                vfg_pkg::VFG_ST_DELAY: begin
                    if (!run_enable_in) begin
                        st_q    <= vfg_pkg::VFG_ST_RUN;
                        tries_q <= 3'b000;
                    end else if (ms_cnt_q >= delay_ms) begin
                        st_q <= vfg_pkg::VFG_ST_RUN;
                        if (tries_cfg != `VFG_TRY_FOREVER) begin
                            tries_q <= tries_q + 3'b001;
                        end
                    end
                end
                vfg_pkg::VFG_ST_HOLD: begin
                    if (resp == `VFG_RESP_RESUME ? below_resume : !over_raw) begin
                        st_q <= vfg_pkg::VFG_ST_RUN;
                    end
                end
                vfg_pkg::VFG_ST_LATCH: begin
                    // Only dropping the enable leaves a spent retry budget
                    if (!run_enable_in) begin
                        st_q    <= vfg_pkg::VFG_ST_RUN;
                        tries_q <= 3'b000;
                    end
                end
                default: begin
                    st_q <= vfg_pkg::VFG_ST_RUN;
                end
            endcase
        end
    end

    // Peer group handling
    logic group_fault;
    logic group_hold_q;
    logic seq_req_q;

    assign group_fault = |(listen_mask_q & peer_sync_q);

    // Hold stays set while the group stays faulted, whatever the modes
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            group_hold_q <= 1'b0;
            seq_req_q    <= 1'b0;
        end else if (group_fault && spread_mode_in) begin
            group_hold_q <= 1'b1;
            seq_req_q    <= 1'b0;
        end else if (group_fault && seq_enable_in) begin
            group_hold_q <= 1'b1;
            seq_req_q    <= 1'b1;
        end else if (!group_fault) begin
            group_hold_q <= 1'b0;
            seq_req_q    <= 1'b0;
        end
    end

    // Immediate cut in spread mode; without either mode peers are ignored
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_enable_out <= 1'b0;
        end else begin
            out_enable_out <= run_enable_in && !ov_off && !(group_fault && spread_mode_in)
                              && !group_hold_q;
        end
    end

    assign seq_shutdown_out  = seq_req_q;
    assign rail_shutdown_out = !out_enable_out && share_off_q[1];

    // Snapshot control
    logic snap_frozen_q;
    logic snap_fault;

    // A host store and a fault store in one cycle give one pulse
    assign snap_fault = unmasked_fault_in || over_raw;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            snap_frozen_q <= 1'b0;
            nvm_op_out    <= '0;
        end else begin
            if (snap_fault) begin
                snap_frozen_q <= 1'b1;
            end
            nvm_op_out.copy  <= wr_capture && (cmd_in.data[7:0] == `VFG_CAP_COPY);
            nvm_op_out.erase <= wr_capture && (cmd_in.data[7:0] == `VFG_CAP_ERASE);
            nvm_op_out.store <= (wr_capture && (cmd_in.data[7:0] == `VFG_CAP_STORE))
                                || (snap_fault && !snap_frozen_q);
        end
    end

    assign snap_refresh_out = !snap_frozen_q;

endmodule : vfg_fault_group

/* sim/vfg_fault_group_chk.sv */
/*
 Port checker for the fault group block, bound onto every instance.
 Assumes the defines header and package are compiled before it.
*/
`timescale 1ns/10ps
`include "vfg_defines.svh"
module vfg_fault_group_chk #(
    parameter int unsigned MS_CYCLES = 4
) (
    input  wire logic            core_clk_in,
    input  wire logic            rst_n_in,
    input  wire logic            share_peers_off_in,
    input  vfg_pkg::vfg_cmd_s    cmd_in,
    input  wire logic            rd_valid_out,
    input  wire logic [15:0]     supply_volts_in,
    input  wire logic            unmasked_fault_in,
    input  wire logic            out_enable_out,
    input  wire logic            rail_shutdown_out,
    input  wire logic            alert_n_out,
    input  wire logic            over_fault_out,
    input  wire logic            snap_refresh_out,
    input  vfg_pkg::vfg_nvm_op_s nvm_op_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [15:0] lim_q;
    logic        cap_wr;
    assign cap_wr = cmd_in.wr && cmd_in.code == `VFG_OFS_CAPTURE;
    // Mirror of the over limit, the ports hide it
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lim_q <= `VFG_RST_OVER_LIMIT;
        end else if (cmd_in.wr && cmd_in.code == `VFG_OFS_OVER_LIMIT) begin
            lim_q <= cmd_in.data[15:0];
        end
    end
    read_answer_a: assert property (cmd_in.rd |=> rd_valid_out) else $error("read not answered");
    copy_op_a: assert property (cap_wr && cmd_in.data[7:0] == `VFG_CAP_COPY |=> nvm_op_out.copy)
        else $error("copy missing");
    store_op_a: assert property (cap_wr && cmd_in.data[7:0] == `VFG_CAP_STORE |=> nvm_op_out.store)
        else $error("store missing");
    erase_op_a: assert property (cap_wr && cmd_in.data[7:0] == `VFG_CAP_ERASE |=> nvm_op_out.erase)
        else $error("erase missing");
    over_detect_a: assert property ($signed({supply_volts_in[10], supply_volts_in[10:0]})
        > $signed({lim_q[10], lim_q[10:0]}) |=> over_fault_out) else $error("over fault not set");
    alert_follows_a: assert property (over_fault_out |-> !alert_n_out) else $error("alert not low");
    rail_report_a: assert property (rail_shutdown_out |-> !out_enable_out && $past(share_peers_off_in, 2))
        else $error("rail off early");
    snap_freeze_a: assert property ($rose(unmasked_fault_in) && snap_refresh_out
        |=> nvm_op_out.store && !snap_refresh_out) else $error("snapshot not stored");
    snap_stays_a: assert property (!snap_refresh_out |=> !snap_refresh_out) else $error("snapshot resumed");
endmodule : vfg_fault_group_chk

bind vfg_fault_group vfg_fault_group_chk #(.MS_CYCLES(MS_CYCLES)) chk (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .share_peers_off_in(share_peers_off_in),
    .cmd_in(cmd_in), .rd_valid_out(rd_valid_out),
    .supply_volts_in(supply_volts_in), .unmasked_fault_in(unmasked_fault_in), .out_enable_out(out_enable_out),
    .rail_shutdown_out(rail_shutdown_out), .alert_n_out(alert_n_out), .over_fault_out(over_fault_out),
    .snap_refresh_out(snap_refresh_out), .nvm_op_out(nvm_op_out));

/* sim/vfg_peer_model.sv */
/*
 Peer rail model on the group bus, one fault event per call.
 Assumes the link clock is made by the bench.
*/
`timescale 1ns/10ps
module vfg_peer_model (
    input  wire logic              link_clk_in,
    output vfg_pkg::vfg_peer_evt_s evt_out
);
    initial evt_out = '0;
    task automatic send(input logic fault, input logic [4:0] rail);
        @(negedge link_clk_in);
        evt_out = '{valid: 1'b1, fault: fault, rail_id: rail};
        @(negedge link_clk_in);
        // Released fields show the inverse, never the stale value
        evt_out = '{valid: 1'b0, fault: !fault, rail_id: ~rail};
    endtask : send
endmodule : vfg_peer_model

/* sim/tb_top.sv */
/*
 Self-checking bench: registers, snapshot, warnings, peers, over response.
 Assumes the design, checker and peer model are compiled before it.
*/
`timescale 1ns/10ps
`include "vfg_defines.svh"
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
    logic                   core_clk_in, link_clk_in, rst_n_in, rd_valid, spread, seq, share_off, run_en;
    logic                   clr, unmasked, out_en, seq_sd, rail_sd, alert_n, ov_f, uv_f, ov_w, uv_w, snap;
    logic [31:0]            rd_data;
    logic [15:0]            supply;
    vfg_pkg::vfg_cmd_s      cmd;
    vfg_pkg::vfg_peer_evt_s peer_evt;
    vfg_pkg::vfg_nvm_op_s   nvm;
    int                     errors, check_count, cycles;
    logic [15:0]            sv [3] = '{16'h0069, 16'h0096, 16'h00be};
    logic [1:0]             ex [3] = '{2'h1, 2'h0, 2'h2};

    // Short millisecond keeps retry waits near 140 cycles
    vfg_fault_group #(.MS_CYCLES(4)) uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .link_clk_in(link_clk_in), .cmd_in(cmd), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .peer_evt_in(peer_evt), .spread_mode_in(spread), .seq_enable_in(seq), .share_peers_off_in(share_off),
        .run_enable_in(run_en), .supply_volts_in(supply), .clear_faults_in(clr), .unmasked_fault_in(unmasked),
        .out_enable_out(out_en), .seq_shutdown_out(seq_sd), .rail_shutdown_out(rail_sd), .alert_n_out(alert_n),
        .over_fault_out(ov_f), .under_fault_out(uv_f), .over_warn_out(ov_w), .under_warn_out(uv_w),
        .snap_refresh_out(snap), .nvm_op_out(nvm));
    vfg_peer_model peer (.link_clk_in(link_clk_in), .evt_out(peer_evt));

    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #7;
        forever #24 link_clk_in = ~link_clk_in;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [7:0] code, input logic [31:0] data);
        @(negedge core_clk_in);
        cmd = '{wr: 1'b1, rd: 1'b0, code: code, data: data};
        @(negedge core_clk_in);
        cmd.wr = 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] code, input logic [31:0] exp);
        @(negedge core_clk_in);
        cmd = '{wr: 1'b0, rd: 1'b1, code: code, data: 32'h0000_0000};
        @(negedge core_clk_in);
        cmd.rd = 1'b0;
        `CHK(rd_valid, 1'b1, "read valid")
        `CHK(rd_data, exp, "read data")
    endtask : rd_chk
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : idle
    // Bounded wait, then compare
    task automatic wait_en(input logic v, input int n);
        for (int i = 0; i < n && out_en !== v; i++) @(negedge core_clk_in);
        `CHK(out_en, v, "output enable")
    endtask : wait_en

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        {rst_n_in, spread, seq, share_off, clr, unmasked} = '0;
        cmd = '0;
        run_en = 1'b1;
        supply = 16'h0000;
        repeat (10) @(posedge core_clk_in);
        @(negedge core_clk_in);
        rst_n_in = 1'b1;
        `CHK({alert_n, snap}, 2'h3, "reset levels")
        rd_chk(`VFG_OFS_LISTEN, `VFG_RST_LISTEN);
        rd_chk(8'h20, 32'h0000_0000);
        wr(`VFG_OFS_LISTEN, 32'h8000_0021);
        rd_chk(`VFG_OFS_LISTEN, 32'h8000_0021);
        run_en = 1'b0;
        idle(2);
        for (int c = 1; c <= 4; c++) begin
            wr(`VFG_OFS_CAPTURE, 32'(c));
            `CHK(nvm, {c == 1, c == 2, c == 3}, "capture op")
        end
        rd_chk(`VFG_OFS_CAPTURE, 32'h0000_0004);
        run_en = 1'b1;
        wr(`VFG_OFS_OVER_LIMIT, 32'h0000_00c8);
        wr(`VFG_OFS_UNDER_LIMIT, 32'h0000_0064);
        rd_chk(`VFG_OFS_OVER_LIMIT, 32'h0000_00c8);
        `CHK(uv_f, 1'b1, "under fault")
        for (int i = 0; i < 3; i++) begin
            supply = sv[i];
            idle(2);
            `CHK({ov_w, uv_w}, ex[i], "warn levels")
        end
        supply = 16'h0096;
        spread = 1'b1;
        // Rail 6 is not listened to, so the output stays enabled
        peer.send(1'b1, 5'h06);
        idle(12);
        `CHK(out_en, 1'b1, "unlisted rail")
        peer.send(1'b1, 5'h05);
        peer.send(1'b1, 5'h1f);
        wait_en(1'b0, 12);
        share_off = 1'b1;
        idle(4);
        `CHK(rail_sd, 1'b1, "rail off")
        share_off = 1'b0;
        idle(4);
        `CHK(rail_sd, 1'b0, "rail partly on")
        peer.send(1'b0, 5'h05);
        idle(12);
        `CHK(out_en, 1'b0, "group not clear")
        peer.send(1'b0, 5'h1f);
        wait_en(1'b1, 12);
        {spread, seq} = 2'h1;
        peer.send(1'b1, 5'h05);
        idle(12);
        `CHK(seq_sd, 1'b1, "sequenced off")
        peer.send(1'b0, 5'h05);
        idle(12);
        `CHK(seq_sd, 1'b0, "sequenced restart")
        seq = 1'b0;
        peer.send(1'b1, 5'h05);
        idle(12);
        `CHK({out_en, seq_sd}, 2'h2, "peers ignored")
        peer.send(1'b0, 5'h05);
        idle(1);
        unmasked = 1'b1;
        idle(1);
        `CHK(nvm, 3'h2, "snapshot store")
        unmasked = 1'b0;
        idle(1);
        `CHK(snap, 1'b0, "snapshot frozen")
        wr(`VFG_OFS_OVER_ACTION, 32'h0000_0000);
        supply = 16'h00d2;
        idle(3);
        `CHK({out_en, alert_n, ov_f}, 3'h5, "ignore mode")
        supply = 16'h0096;
        clr = 1'b1;
        idle(1);
        clr = 1'b0;
        idle(1);
        `CHK({alert_n, uv_f, ov_f}, 3'h4, "alert cleared")
        wr(`VFG_OFS_OVER_ACTION, 32'h0000_0088);
        supply = 16'h00d2;
        wait_en(1'b0, 3);
        supply = 16'h0096;
        idle(125);
        `CHK(out_en, 1'b0, "retry too soon")
        wait_en(1'b1, 30);
        wr(`VFG_OFS_OVER_ACTION, 32'h0000_00c0);
        supply = 16'h00d2;
        wait_en(1'b0, 3);
        supply = 16'h00c0;
        idle(10);
        `CHK(out_en, 1'b0, "above resume level")
        supply = 16'h00bd;
        wait_en(1'b1, 5);
        wr(`VFG_OFS_OVER_ACTION, 32'h0000_0080);
        supply = 16'h00d2;
        wait_en(1'b0, 3);
        idle(200);
        `CHK(out_en, 1'b0, "no retry")
        supply = 16'h00c8;
        wait_en(1'b1, 5);
        // One retry already used, so the next trip latches off
        wr(`VFG_OFS_OVER_ACTION, 32'h0000_0088);
        supply = 16'h00d2;
        wait_en(1'b0, 3);
        supply = 16'h0096;
        idle(160);
        `CHK(out_en, 1'b0, "retry budget spent")
        run_en = 1'b0;
        idle(2);
        run_en = 1'b1;
        wait_en(1'b1, 5);
        end_sim();
    end
endmodule : tb_top
